// >>> sieie_top.sv
// top: APB register file, input synchronisers and interrupt output for twelve switch inputs
`timescale 1ns/1ps
module sieie_top
	import sieie_pkg::*;
(
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// comparator results, asynchronous
	input wire logic [SIEIE_NUM_INPUTS-1:0] threshold_above,
	// interrupt
	output logic irq_n
);
	typedef struct packed {
		logic [SIEIE_NUM_INPUTS-1:0] sync1;
		logic [SIEIE_NUM_INPUTS-1:0] sync2;
		logic [SIEIE_SEL_W-1:0] select;
		logic [SIEIE_NUM_INPUTS-1:0] status;
		logic [SIEIE_NUM_INPUTS-1:0] enable;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic irq_n;
	} sieie_top_s;
	sieie_top_s st_reg;
	sieie_top_s st_next;
	logic [SIEIE_NUM_INPUTS-1:0] hits;

	// register map, word aligned, byte address is four times the index:
	//   select (25h): twelve 2-bit edge-select fields, read-write, reset zero
	//   status (40h): sticky edge flags, read only
	//   clear  (41h): write one to drop a status flag, reads zero
	//   enable (42h): per-input interrupt enable, read-write, reset zero
	//   level  (43h): synchronised comparator levels, read only
	// any other address answers with an error and reads zero
	//
	// bus timing:
	//   the first access-phase edge is taken, ready follows one cycle later
	//   a write lands on the taken edge, so a read right after sees it
	//   ready, error and read data stand for exactly one cycle
	//   read data is forced to zero outside that cycle
	//
	// input path:
	//   two synchroniser flops, then the detector flop, then the status flop
	//   status and the interrupt level move on the same edge
	//   an input change shows on the interrupt three edges after it is sampled
	//
	// limitations:
	//   a pulse shorter than one clock may be lost in the synchroniser
	//   a level already high at reset release is seen as a rising edge,
	//   because the previous sample starts low; software should clear status
	//   after it programs the select fields if that matters
	//   status flags set whatever the enables say, enables only gate the pin
	//
	// trade-off:
	//   the wait state keeps the decode off the output path, so every bus
	//   output leaves a flop; it costs one cycle per transfer

	// zero-extend the flag set onto the data bus
	function automatic logic [31:0] sieie_word(input logic [SIEIE_NUM_INPUTS-1:0] f);
		sieie_word = {{(32-SIEIE_NUM_INPUTS){1'b0}}, f};
	endfunction

	// zero-extend the select fields onto the data bus
	function automatic logic [31:0] sieie_sel_word(input logic [SIEIE_SEL_W-1:0] s);
		sieie_sel_word = {{(32-SIEIE_SEL_W){1'b0}}, s};
	endfunction

	// one detector per input, fed from its own field
	for (genvar n = 0; n < SIEIE_NUM_INPUTS; n++) begin : g_det
		sieie_edge_det u_det (
			.pclk(pclk),
			.presetn(presetn),
			.level(st_reg.sync2[n]),
			.edge_select(st_reg.select[SIEIE_FIELD_W*n +: SIEIE_FIELD_W]),
			.edge_hit(hits[n])
		);
	end

	// merge write data under byte strobes
	function automatic logic [31:0] sieie_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		sieie_merge = r;
	endfunction

	// bus access, status set/clear and interrupt level
	always_comb begin
		logic access;
		logic wr;
		logic [31:0] w;
		logic [SIEIE_NUM_INPUTS-1:0] clr;
		access = 1'b0;
		wr = 1'b0;
		w = '0;
		clr = '0;
		st_next = st_reg;
		// two-flop synchroniser; only the second stage is read
		st_next.sync1 = threshold_above;
		st_next.sync2 = st_reg.sync1;
		// one wait state: ready rises one cycle into the access phase
		access = psel & penable & ~st_reg.ready;
		wr = access & pwrite;
		st_next.ready = access;
		st_next.slverr = 1'b0;
		st_next.rdata = SIEIE_RDATA_RST;
		if (access) begin
			case (paddr)
				// edge-select fields; the top byte has no storage
				sieie_addr(SIEIE_IDX_SELECT): begin
					if (wr) begin
						// strobes keep untouched lanes, so one byte can be patched
						w = sieie_merge(sieie_sel_word(st_reg.select), pwdata, pstrb);
						st_next.select = w[SIEIE_SEL_W-1:0];
					end else begin
						st_next.rdata = sieie_sel_word(st_reg.select);
					end
				end
				// sticky flags; writes are dropped, clearing goes through its own word
				sieie_addr(SIEIE_IDX_STATUS): begin
					if (!wr) begin
						st_next.rdata = sieie_word(st_reg.status);
					end
				end
				// write-one-to-clear, nothing to read back
				sieie_addr(SIEIE_IDX_CLEAR): begin
					if (wr) begin
						w = sieie_merge(32'h0000_0000, pwdata, pstrb);
						clr = w[SIEIE_NUM_INPUTS-1:0];
					end
				end
				sieie_addr(SIEIE_IDX_ENABLE): begin
					if (wr) begin
						w = sieie_merge(sieie_word(st_reg.enable), pwdata, pstrb);
						st_next.enable = w[SIEIE_NUM_INPUTS-1:0];
					end else begin
						st_next.rdata = sieie_word(st_reg.enable);
					end
				end
				// live levels after the synchroniser, never the raw pins
				sieie_addr(SIEIE_IDX_LEVEL): begin
					if (!wr) begin
						st_next.rdata = sieie_word(st_reg.sync2);
					end
				end
				default: st_next.slverr = 1'b1; // unmapped: error, reads zero
			endcase
		end
		// a new edge in the clearing cycle stays set
		st_next.status = (st_reg.status & ~clr) | hits;
		// level output, low while any enabled flag stands
		st_next.irq_n = ~|(st_next.status & st_reg.enable);
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.select <= SIEIE_SELECT_RST;
			st_reg.status <= SIEIE_FLAGS_RST;
			st_reg.enable <= SIEIE_FLAGS_RST;
			st_reg.irq_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign pready = st_reg.ready;
	assign pslverr = st_reg.slverr;
	assign irq_n = st_reg.irq_n;
endmodule

// >>> sieie_pkg.sv
// package: register map, field layout and codes for the switch input edge interrupt block
package sieie_pkg;
	localparam int SIEIE_NUM_INPUTS = 12;
	localparam int SIEIE_FIELD_W = 2;
	localparam int SIEIE_SEL_W = 24;
	localparam logic [7:0] SIEIE_IDX_SELECT = 8'h25;
	localparam logic [7:0] SIEIE_IDX_STATUS = 8'h40;
	localparam logic [7:0] SIEIE_IDX_CLEAR = 8'h41;
	localparam logic [7:0] SIEIE_IDX_ENABLE = 8'h42;
	localparam logic [7:0] SIEIE_IDX_LEVEL = 8'h43;
	localparam logic [SIEIE_SEL_W-1:0] SIEIE_SELECT_RST = 24'h00_0000;
	localparam logic [SIEIE_NUM_INPUTS-1:0] SIEIE_FLAGS_RST = 12'h000;
	localparam logic [31:0] SIEIE_RDATA_RST = 32'h0000_0000;
	typedef enum logic [1:0] {
		SIEIE_EDGE_NONE,
		SIEIE_EDGE_RISE,
		SIEIE_EDGE_FALL,
		SIEIE_EDGE_BOTH
	} sieie_edge_e;
	// byte address of a register index, word aligned
	function automatic logic [11:0] sieie_addr(input logic [7:0] idx);
		sieie_addr = {2'b00, idx, 2'b00};
	endfunction
endpackage

// >>> sieie_edge_det.sv
// per-input edge detector steered by a 2-bit edge-select code
`timescale 1ns/1ps
module sieie_edge_det
	import sieie_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// synchronised comparator level and its select code
	input wire logic level,
	input wire logic [1:0] edge_select,
	// one-cycle event
	output logic edge_hit
);
	typedef struct packed {
		logic prev;
		logic hit;
	} sieie_det_s;
	sieie_det_s st_reg;
	sieie_det_s st_next;

	// compare current sample with the previous one
	always_comb begin
		st_next = st_reg;
		st_next.prev = level;
		case (sieie_edge_e'(edge_select))
			SIEIE_EDGE_NONE: st_next.hit = 1'b0;
			SIEIE_EDGE_RISE: st_next.hit = level & ~st_reg.prev;
			SIEIE_EDGE_FALL: st_next.hit = ~level & st_reg.prev;
			SIEIE_EDGE_BOTH: st_next.hit = level ^ st_reg.prev;
			default: st_next.hit = 1'b0;
		endcase
	end

	// prev starts low, so a level high at reset release counts as rising
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign edge_hit = st_reg.hit;
endmodule

// >>> sieie_monitor.sv
// checker: bus handshake and interrupt output of the edge interrupt block
`timescale 1ns/1ps
module sieie_monitor(
	// clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	// answer, inputs, interrupt
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [11:0] threshold_above,
	input wire logic irq_n
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// one wait state, then a single-cycle answer
	AST_WAIT_ONE: assert property (psel && penable && !pready |=> pready) else $error("no answer");
	AST_PULSE: assert property (pready |=> !pready) else $error("long ready");
	AST_IN_ACCESS: assert property (pready |-> psel && penable) else $error("stray ready");
	AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0000_0000) else $error("idle data");
	AST_ERR_RDY: assert property (pslverr |-> pready) else $error("stray error");
	AST_SEL_MAP: assert property (pready && paddr == 12'h094 |-> !pslverr) else $error("select unmapped");
	// fields fill 24 bits only, the top byte reads zero
	AST_SEL_WIDTH: assert property (pready && !pwrite && paddr == 12'h094 |-> prdata[31:24] == 8'h00)
		else $error("high bits");
	// a fall needs an input change five edges back or a write answered just before
	AST_IRQ_CAUSE: assert property ($fell(irq_n) |-> $past(threshold_above, 4) != $past(threshold_above, 5)
		|| $past(pready && pwrite)) else $error("irq no cause");
endmodule
bind sieie_top sieie_monitor u_mon(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .threshold_above, .irq_n);

// >>> sieie_switch_model.sv
// comparator stand-in: input levels cross the threshold at clock edges
`timescale 1ns/1ps
module sieie_switch_model(
	// clock and wanted levels
	input wire logic pclk,
	input wire logic [11:0] want,
	// comparator results
	output logic [11:0] threshold_above
);
	initial threshold_above = 12'h000;
	// clean crossings, no bounce, so each change is one edge
	always @(posedge pclk) threshold_above <= want;
endmodule

// >>> tb.sv
// testbench: register access, edge selection and interrupt masking
`timescale 1ns/1ps
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq_n, er;
	logic [11:0] paddr = 0, want = 0, thr;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] strb = 4'hf;
	int err_count = 0, n_compared = 0, cyc = 0;
	always #5 pclk = ~pclk;
	sieie_top u_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(strb), .prdata,
		.pready, .pslverr, .threshold_above(thr), .irq_n);
	sieie_switch_model u_sw(.pclk, .want, .threshold_above(thr));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// one transfer; an idle edge first keeps psel from two writes in one step
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1) err_count++;
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	always @(posedge pclk) if (++cyc == 3000) begin
		err_count++;
		close_out;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h25, 0);
		chk(rd, 0);
		chk(er, 0);
		chk(irq_n, 1);
		// input n gets code n mod 4
		apb(1, 8'h25, 32'hffe4_e4e4);
		apb(0, 8'h25, 0);
		chk(rd, 32'h00e4_e4e4);
		// only the unused top lane strobed: fields must survive
		strb <= 4'h8;
		apb(1, 8'h25, 0);
		strb <= 4'hf;
		apb(0, 8'h25, 0);
		chk(rd, 32'h00e4_e4e4);
		apb(1, 8'h42, 32'h0000_0fff);
		apb(0, 8'h42, 0);
		chk(rd, 32'h0000_0fff);
		want <= 12'hfff;
		repeat (8) @(posedge pclk);
		chk(irq_n, 0);
		apb(0, 8'h40, 0);
		chk(rd, 32'h0000_0aaa);
		apb(1, 8'h41, 32'h0000_0fff);
		want <= 12'h000;
		repeat (8) @(posedge pclk);
		apb(0, 8'h40, 0);
		chk(rd, 32'h0000_0ccc);
		apb(1, 8'h41, 32'h0000_0fff);
		apb(1, 8'h42, 0);
		$display("edge test done");
		want <= 12'hfff;
		repeat (8) @(posedge pclk);
		chk(irq_n, 1);
		apb(0, 8'h40, 0);
		chk(rd, 32'h0000_0aaa);
		apb(0, 8'h30, 0);
		chk(er, 1);
		apb(0, 8'h43, 0);
		chk(rd, 32'h0000_0fff);
		$display("mask test done");
		close_out;
	end
endmodule
